// ===== logic/hfc_pkg.sv
package hfc_pkg;
  // register port geometry
  localparam int REG_AW = 3;
  localparam int REG_DW = 16;
  // register indices: line_control_word, adapter_status_word, data_fifo_port
  localparam logic [2:0] IDX_CTL = 3'h2;
  localparam logic [2:0] IDX_STAT = 3'h5;
  localparam logic [2:0] IDX_DATA = 3'h7;
  // line_control_word fields and value after master clear
  localparam int CTL_RXEN = 0;
  localparam int CTL_TXEN = 1;
  localparam int CTL_CRCEN = 2;
  localparam logic [2:0] CTL_RST = 3'h0;
  // adapter_status_word fields
  localparam int ST_RXRDY = 0;
  localparam int ST_TXRDY = 1;
  localparam int ST_TU = 2;
  localparam int ST_TFNE = 3;
  // receive status byte fields (entry bits 12:8)
  localparam int RS_OVR = 0;
  localparam int RS_ABT = 1;
  localparam int RS_EOF = 2;
  localparam int RS_FCS = 3;
  localparam int RS_IDLE = 4;
  // transmit control byte fields (write data bits 15:8)
  localparam int TC_SOF = 0;
  localparam int TC_EOF = 1;
  // fifo shape
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  // line patterns and run lengths
  localparam logic [7:0] FLAG = 8'h7E;
  localparam logic [7:0] MARK = 8'hFF;
  localparam logic [3:0] ABORT_ONES = 4'h6;
  localparam logic [3:0] IDLE_ONES = 4'hE;
  localparam logic [3:0] STUFF_ONES = 4'h5;
  localparam logic [2:0] TX_STUFF_ONES = 3'h5;
  // frame check sequence, reflected ccitt form
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  // state types
  typedef enum logic [0:0] {RX_HUNT, RX_DATA} hfc_rx_st_t;
  typedef enum logic [2:0] {TX_IDLE, TX_FLAG, TX_DATA, TX_CRC, TX_ABORT} hfc_tx_st_t;
endpackage : hfc_pkg

// ===== logic/hfc_channel.sv
// Function
// RULE1 - once flag-synchronised, each received byte enters the rx fifo with a status byte
// RULE2 - a push into an empty rx fifo raises a service request; ready goes true
// RULE3 - host reads head entry at index 7 while ready; each read pops one
// RULE4 - rx fifo overflow sets the overrun mark in the newest entry
// RULE5 - host discards rest of an overrun frame through its end mark
// RULE6 - after overrun the next frame loads normally once space exists
// RULE7 - bytes are loaded until a flag or abort ends the frame
// RULE8 - abort marks newest entry abort plus end; loading stops until resync
// RULE9 - closing flag loads last byte with end mark and check result
// RULE10 - a following frame is loaded the same way without host help
// RULE11 - fifteen ones mean idle line; one idle mark posted between frames
// RULE12 - master clear turns the line control bits off, disconnecting the line
// RULE13 - with control loaded the transmitter connects and marks the line
// RULE14 - tx enabled and start mark at head: send opening flag then contents
// RULE15 - each write enters tx fifo with control byte; ready while not full
// RULE16 - tx service request when ready rises while tx enable is set
// RULE17 - tx underflow sets underrun, sends abort then flags, discards data
// RULE18 - host checks underrun; next start mark clears stored underrun
// RULE19 - host writes last byte of a frame with the end mark set
// RULE20 - end-marked byte is sent, then check sequence, then closing flag
// RULE21 - at high rates host loop time at least twice its adapter accesses
// RULE22 - flag 01111110 searched on every bit; seven ones are an abort
// RULE23 - ccitt check sequence generated and checked
// RULE24 - no service requests from a channel whose enable bit is clear
// RULE25 - receive service is preferred over transmit service
// RULE26 - zero inserted after five data ones on send, deleted on receive
// RULE27 - after idle nothing more is loaded, so ready stays low
`timescale 1ns/1ps
module hfc_channel (
  // clock and master clear
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [hfc_pkg::REG_AW-1:0] reg_addr,
  input wire logic [hfc_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [hfc_pkg::REG_DW-1:0] reg_rdata,
  // service requests
  output logic channel_service_request,
  output logic service_is_rx,
  // data circuit, clocks supplied by the modem
  input wire logic rx_line_clk,
  input wire logic rx_line_data,
  input wire logic tx_line_clk,
  output logic tx_line_data,
  output logic dce_connect
);
  import hfc_pkg::*;

  function automatic logic [15:0] crcb(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crcb

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [2:0] ctl_r;
  logic [15:0] rdata_r;
  logic csr_r, csr_rx_r, tx_pend_r, txrdy_d_r, dce_r, txd_r;
  logic [2:0] rck_s, tck_s;
  logic [1:0] rd_s;

  // two flops on every line input before use; stage 2 of the clocks feeds edge detect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rck_s <= 3'h0;
      tck_s <= 3'h0;
      rd_s <= 2'h3;
    end else begin
      rck_s <= {rck_s[1:0], rx_line_clk};
      tck_s <= {tck_s[1:0], tx_line_clk};
      rd_s <= {rd_s[0], rx_line_data};
    end
  end

  // ---------------- receive fifo ----------------
  logic [12:0] rx_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] rx_wp, rx_rp;
  logic [FIFO_AW:0] rx_cnt;
  logic push_en;
  logic [7:0] push_dat;
  logic [4:0] push_st;
  wire rx_full = rx_cnt == 4'(FIFO_DEPTH);
  wire rx_empty = rx_cnt == 4'h0;
  wire sel_data = reg_addr == IDX_DATA;
  wire rx_pop = reg_rd & sel_data & ~rx_empty; // RULE3
  wire rx_do_push = push_en & ~rx_full;
  wire [FIFO_AW-1:0] rx_newest = rx_wp - 3'h1;

  // memory has no reset; pointers and count do
  always_ff @(posedge clk) begin
    if (rx_do_push) rx_mem[rx_wp] <= {push_st, push_dat}; // RULE1
    if (push_en & rx_full) rx_mem[rx_newest][8+RS_OVR] <= 1'b1; // RULE4
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_wp <= 3'h0;
      rx_rp <= 3'h0;
      rx_cnt <= 4'h0;
    end else begin
      if (rx_do_push) rx_wp <= rx_wp + 3'h1;
      if (rx_pop) rx_rp <= rx_rp + 3'h1;
      rx_cnt <= rx_cnt + {3'h0, rx_do_push} - {3'h0, rx_pop};
    end
  end

  // ---------------- receive serial engine ----------------
  hfc_rx_st_t rx_st_r;
  logic [3:0] ones_r;
  logic [7:0] sh_r, asm_r, pend_r;
  logic [2:0] bcnt_r;
  logic hpend_r, idle_r;
  logic [15:0] crc_r;
  wire rbit = rd_s[1];
  wire rx_go = rck_s[1] & ~rck_s[2] & ctl_r[CTL_RXEN];
  wire in_data = rx_st_r == RX_DATA;
  wire flag_det = {rbit, sh_r[7:1]} == FLAG; // RULE22
  wire abort_det = rbit & (ones_r == ABORT_ONES); // RULE22
  wire idle_det = rbit & (ones_r == IDLE_ONES) & ~idle_r; // RULE11
  wire stuffed = ~rbit & (ones_r == STUFF_ONES); // RULE26
  wire [7:0] asm_nxt = {rbit, asm_r[7:1]};
  wire byte_done = in_data & ~stuffed & (bcnt_r == 3'h7) & ~flag_det & ~abort_det & ~idle_det;
  wire close_ok = flag_det & in_data & hpend_r & (bcnt_r == 3'h7);
  wire fcs_bad = crc_r != CRC_GOOD; // RULE23

  // what goes into the bottom of the fifo; the last pending byte carries the end marks
  assign push_en = rx_go & (idle_det | (abort_det & in_data & hpend_r) | close_ok | (byte_done & hpend_r)); // RULE7
  assign push_dat = idle_det ? 8'h00 : pend_r;
  assign push_st = idle_det ? 5'(1 << RS_IDLE) : // RULE11
                   abort_det ? 5'((1 << RS_ABT) | (1 << RS_EOF)) : // RULE8
                   flag_det ? 5'((1 << RS_EOF) | (fcs_bad << RS_FCS)) : 5'h00; // RULE9

  // one byte is held back so the flag bits that reach the assembler never get loaded
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_r <= RX_HUNT;
      ones_r <= 4'h0;
      sh_r <= 8'h00;
      asm_r <= 8'h00;
      pend_r <= 8'h00;
      bcnt_r <= 3'h0;
      hpend_r <= 1'b0;
      idle_r <= 1'b0;
      crc_r <= CRC_INIT;
    end else if (!ctl_r[CTL_RXEN]) begin
      rx_st_r <= RX_HUNT;
      hpend_r <= 1'b0;
    end else if (rx_go) begin
      sh_r <= {rbit, sh_r[7:1]};
      ones_r <= rbit ? ((ones_r == 4'hF) ? 4'hF : ones_r + 4'h1) : 4'h0;
      if (idle_det | abort_det) begin
        rx_st_r <= RX_HUNT; // RULE8 RULE27
        hpend_r <= 1'b0;
        if (idle_det) idle_r <= 1'b1; // RULE11
      end else if (flag_det) begin
        rx_st_r <= RX_DATA; // RULE10 RULE6
        bcnt_r <= 3'h0;
        hpend_r <= 1'b0;
        crc_r <= CRC_INIT;
        idle_r <= 1'b0;
      end else if (in_data & ~stuffed) begin
        asm_r <= asm_nxt;
        bcnt_r <= bcnt_r + 3'h1;
        if (bcnt_r == 3'h7) begin
          pend_r <= asm_nxt;
          hpend_r <= 1'b1;
          crc_r <= crcb(crc_r, asm_nxt); // RULE23
        end
      end
    end
  end

  // ---------------- transmit fifo ----------------
  logic [9:0] tx_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] tx_wp, tx_rp;
  logic [FIFO_AW:0] tx_cnt;
  logic tpop;
  wire tx_full = tx_cnt == 4'(FIFO_DEPTH);
  wire tx_empty = tx_cnt == 4'h0;
  wire tx_push = reg_wr & sel_data & ~tx_full; // RULE15
  wire [9:0] thead = tx_mem[tx_rp];
  wire hsof = ~tx_empty & thead[8+TC_SOF];
  wire tx_en = ctl_r[CTL_TXEN];

  always_ff @(posedge clk) begin
    if (tx_push) tx_mem[tx_wp] <= {reg_wdata[9:8], reg_wdata[7:0]};
  end

  // ---------------- transmit serial engine ----------------
  hfc_tx_st_t tx_st_r, nst;
  logic [7:0] tsh_r, nbyte;
  logic [2:0] tbc_r, tones_r;
  logic teof_r, thi_r, tu_r, tu_set, tu_clr, crc_upd, tcont_r;
  logic [15:0] tcrc_r;
  wire tx_go = tck_s[2] & ~tck_s[1]; // change data on the falling line clock
  wire tstuff = (tx_st_r == TX_DATA || tx_st_r == TX_CRC || tcont_r) && tones_r == TX_STUFF_ONES; // RULE26
  wire boundary = tx_go & ~tstuff & (tbc_r == 3'h7);
  wire tx_pop = boundary & tpop;
  wire [15:0] fcs = ~tcrc_r;

  // choice of the next byte at each byte boundary
  always_comb begin
    nst = tx_st_r;
    nbyte = FLAG;
    tpop = 1'b0;
    tu_set = 1'b0;
    tu_clr = 1'b0;
    crc_upd = 1'b0;
    case (tx_st_r)
      TX_IDLE, TX_FLAG: begin
        nbyte = (tx_st_r == TX_IDLE && !(hsof & tx_en)) ? MARK : FLAG; // RULE13 RULE14
        if (~tx_empty & ~hsof) begin
          tpop = 1'b1; // RULE17
        end else if (hsof & tx_en & tx_st_r == TX_IDLE) begin
          nst = TX_FLAG; // RULE14
        end else if (hsof & tx_st_r == TX_FLAG) begin
          nst = TX_DATA;
          nbyte = thead[7:0];
          tpop = 1'b1;
          tu_clr = 1'b1; // RULE18
          crc_upd = 1'b1;
        end else if (tx_st_r == TX_FLAG & ~tx_en & tx_empty) begin
          nst = TX_IDLE;
          nbyte = MARK;
        end
      end
      TX_DATA: begin
        if (teof_r) begin
          nst = ctl_r[CTL_CRCEN] ? TX_CRC : TX_FLAG; // RULE20
          nbyte = ctl_r[CTL_CRCEN] ? fcs[7:0] : FLAG;
        end else if (~tx_empty) begin
          nbyte = thead[7:0];
          tpop = 1'b1;
          crc_upd = 1'b1;
        end else begin
          nst = TX_ABORT; // RULE17
          nbyte = MARK;
          tu_set = 1'b1;
        end
      end
      TX_CRC: begin
        nst = thi_r ? TX_FLAG : TX_CRC; // RULE23
        nbyte = thi_r ? FLAG : fcs[15:8];
      end
      TX_ABORT: nst = TX_FLAG;
      default: nst = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_wp <= 3'h0;
      tx_rp <= 3'h0;
      tx_cnt <= 4'h0;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 3'h1;
      if (tx_pop) tx_rp <= tx_rp + 3'h1;
      tx_cnt <= tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
    end
  end

  // a stuffed zero takes a bit slot without consuming a shift bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_st_r <= TX_IDLE;
      tsh_r <= MARK;
      tbc_r <= 3'h0;
      tones_r <= 3'h0;
      teof_r <= 1'b0;
      thi_r <= 1'b0;
      tcont_r <= 1'b0;
      tu_r <= 1'b0;
      tcrc_r <= CRC_INIT;
      txd_r <= 1'b1;
    end else if (tx_go) begin
      txd_r <= ~dce_r | (~tstuff & tsh_r[0]);
      if (tstuff) begin
        tones_r <= 3'h0; // RULE26
      end else begin
        tones_r <= tsh_r[0] ? ((tones_r == 3'h7) ? 3'h7 : tones_r + 3'h1) : 3'h0;
        tsh_r <= {1'b1, tsh_r[7:1]};
        tcont_r <= (tx_st_r == TX_DATA || tx_st_r == TX_CRC); // last content bits may still owe a stuffed zero
        tbc_r <= tbc_r + 3'h1;
        if (tbc_r == 3'h7) begin
          tx_st_r <= nst;
          tsh_r <= nbyte;
          if (tpop) teof_r <= thead[8+TC_EOF]; // RULE20
          thi_r <= (tx_st_r == TX_CRC);
          if (crc_upd) tcrc_r <= crcb((tx_st_r == TX_DATA) ? tcrc_r : CRC_INIT, thead[7:0]);
          if (tu_set) tu_r <= 1'b1;
          else if (tu_clr) tu_r <= 1'b0;
        end
      end
    end
  end

  // ---------------- registers, requests and read port ----------------
  wire sel_ctl = reg_addr == IDX_CTL;
  wire sel_stat = reg_addr == IDX_STAT;
  wire txrdy = ~tx_full; // RULE15
  wire rx_ev = rx_do_push & rx_empty & ctl_r[CTL_RXEN]; // RULE2 RULE24
  wire tx_ev = txrdy & ~txrdy_d_r & tx_en; // RULE16 RULE24
  wire [3:0] stat = {~tx_empty, tu_r, txrdy, ~rx_empty};
  wire [15:0] rd_mux = sel_ctl ? {13'h0, ctl_r} :
                       sel_stat ? {12'h0, stat} :
                       (sel_data & ~rx_empty) ? {3'h0, rx_mem[rx_rp]} : 16'h0000;

  // a transmit request that collides with a receive one waits a cycle instead of being lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_r <= CTL_RST; // RULE12
      rdata_r <= 16'h0000;
      csr_r <= 1'b0;
      csr_rx_r <= 1'b0;
      tx_pend_r <= 1'b0;
      txrdy_d_r <= 1'b1;
      dce_r <= 1'b0;
    end else begin
      if (reg_wr & sel_ctl) ctl_r <= reg_wdata[2:0];
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
      csr_r <= rx_ev | ((tx_ev | tx_pend_r) & tx_en);
      csr_rx_r <= rx_ev; // RULE25
      tx_pend_r <= (tx_ev | tx_pend_r) & tx_en & rx_ev;
      txrdy_d_r <= txrdy;
      dce_r <= ctl_r[CTL_RXEN] | ctl_r[CTL_TXEN]; // RULE13
    end
  end

  assign reg_rdata = rdata_r;
  assign channel_service_request = csr_r;
  assign service_is_rx = csr_rx_r;
  assign tx_line_data = txd_r;
  assign dce_connect = dce_r;

  // ---------------- checks ----------------
  AST_RX_REQ: assert property (rx_ev |=> channel_service_request && service_is_rx) // RULE2
    else $error("rx push into empty fifo gave no request");
  AST_RX_POP: assert property (rx_pop && !rx_do_push |=> rx_cnt == 4'($past(rx_cnt) - 4'h1)) // RULE3
    else $error("rx read did not pop one entry");
  AST_RX_OVR: assert property (push_en && rx_full |=> rx_mem[$past(rx_newest)][8+RS_OVR]) // RULE4
    else $error("overflow did not mark newest entry");
  AST_RX_ABORT: assert property (rx_go && abort_det && in_data |=> rx_st_r == RX_HUNT) // RULE8
    else $error("abort did not drop sync");
  AST_RX_FLAG: assert property (rx_go && flag_det && !idle_det |=> rx_st_r == RX_DATA && bcnt_r == 3'h0) // RULE22
    else $error("flag did not give sync");
  AST_RX_IDLE: assert property (rx_go && idle_det |=> idle_r && rx_st_r == RX_HUNT ##1 !idle_det) // RULE11
    else $error("idle not latched");
  AST_NO_REQ_OFF: assert property (channel_service_request && service_is_rx |-> $past(ctl_r[CTL_RXEN])) // RULE24
    else $error("rx request while receiver off");
  AST_TX_PUSH: assert property (tx_push && !tx_pop |=> tx_cnt == 4'($past(tx_cnt) + 4'h1)) // RULE15
    else $error("tx write not stored");
  AST_TX_REQ: assert property (tx_ev && !rx_ev ##1 tx_en |-> channel_service_request) // RULE16
    else $error("tx ready rise gave no request");
  AST_UNDERRUN: assert property (boundary && tx_st_r == TX_DATA && !teof_r && tx_empty
                                 |=> tu_r && tx_st_r == TX_ABORT) // RULE17
    else $error("underflow not turned into abort");
  AST_CLEAR: assert property ($rose(resetn) |-> ctl_r == CTL_RST && !dce_connect) // RULE12
    else $error("master clear left line connected");
endmodule : hfc_channel

// ===== testbench/hfc_dce_model.sv
`timescale 1ns/1ps
// modem side of the line: both line clocks, receive bit source, transmit bit decoder
module hfc_dce_model (
  // receive direction
  output logic rx_line_clk,
  output logic rx_line_data,
  // transmit direction
  output logic tx_line_clk,
  input wire logic tx_line_data,
  // decoded transmit bytes
  output logic [7:0] tx_byte,
  output int tx_cnt,
  output int abort_cnt
);
  bit rxq[$];
  int sones = 0;
  int ones = 0;
  int nb = 0;
  bit inf = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] acc = 8'h00;
  // free-running clocks; the tx clock is offset so edges never meet the bench clock
  initial begin
    rx_line_clk = 1'b0;
    rx_line_data = 1'b1;
    tx_line_clk = 1'b0;
    tx_byte = 8'h00;
    tx_cnt = 0;
    abort_cnt = 0;
    #37;
    forever #100 tx_line_clk = ~tx_line_clk;
  end
  always #100 rx_line_clk = ~rx_line_clk;
  // queue bits lsb first; a zero after five data ones keeps content from looking like a flag
  task automatic put(input logic [7:0] v, input bit raw);
    for (int i = 0; i < 8; i++) begin
      rxq.push_back(v[i]);
      sones = v[i] ? sones + 1 : 0;
      if (!raw && sones == 5) begin
        rxq.push_back(1'b0);
        sones = 0;
      end
    end
    if (raw) sones = 0;
  endtask
  // flags fill the gaps, so an idle run only happens when the bench asks for one
  always @(negedge rx_line_clk) begin
    if (rxq.size() == 0) put(8'h7E, 1'b1);
    rx_line_data <= rxq.pop_front();
  end
  // hunt flags on every bit, drop stuffed zeros, collect bytes while in a frame
  always @(posedge tx_line_clk) begin
    sh = {tx_line_data, sh[7:1]};
    if (sh == 8'h7E) begin
      inf = 1'b1;
      nb = 0;
    end else if (!(ones == 5 && !tx_line_data)) begin
      acc = {tx_line_data, acc[7:1]};
      nb++;
      if (nb == 8 && inf) begin
        tx_byte = acc;
        tx_cnt++;
      end
      if (nb == 8) nb = 0;
    end
    ones = tx_line_data ? ones + 1 : 0;
    if (ones == 7) begin
      abort_cnt++;
      inf = 1'b0;
    end
  end
endmodule : hfc_dce_model

// ===== testbench/hfc_channel_bench.sv
`timescale 1ns/1ps
module hfc_channel_bench;
  import hfc_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, channel_service_request, service_is_rx;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata;
  logic rx_line_clk, rx_line_data, tx_line_clk, tx_line_data, dce_connect, rd_pend = 1'b0;
  logic [7:0] tx_byte;
  int tx_cnt, abort_cnt, a0, seen_tx = 0, fails = 0, total_checks = 0, cyc = 0, rxreq = 0, txreq = 0;
  logic [31:0] seed = 32'h9C305C21;
  logic [15:0] exp_q[$], ent[$], c;
  logic [7:0] exp_tx[$], d[12];

  hfc_channel i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_service_request(channel_service_request),
    .service_is_rx(service_is_rx), .rx_line_clk(rx_line_clk), .rx_line_data(rx_line_data),
    .tx_line_clk(tx_line_clk), .tx_line_data(tx_line_data), .dce_connect(dce_connect));
  hfc_dce_model i_dce (.rx_line_clk(rx_line_clk), .rx_line_data(rx_line_data), .tx_line_clk(tx_line_clk),
    .tx_line_data(tx_line_data), .tx_byte(tx_byte), .tx_cnt(tx_cnt), .abort_cnt(abort_cnt));

  always #12.5 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic note(input string s);
    $display("test %s over", s);
  endtask
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // complemented check sequence over d[0..n-1], reflected form
  function automatic logic [15:0] fcs(input int n);
    logic [15:0] r;
    r = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      r = r ^ {8'h00, d[i]};
      for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ CRC_POLY : r >> 1;
    end
    return ~r;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // the read result is noted now and compared by the watcher in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic lwait(input int n);
    repeat ((n + 4) * 80) @(posedge clk);
  endtask
  task automatic drain();
    while (ent.size() != 0) rd(IDX_DATA, ent.pop_front());
  endtask
  // one frame from d[], optionally with a spoiled check sequence; its fifo entries are noted
  task automatic rx_frame(input int n, input bit bad);
    c = fcs(n) ^ {15'h0000, bad};
    i_dce.put(FLAG, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_dce.put(d[i], 1'b0);
      ent.push_back({8'h00, d[i]});
    end
    i_dce.put(c[7:0], 1'b0);
    i_dce.put(c[15:8], 1'b0);
    i_dce.put(FLAG, 1'b1);
    ent.push_back({8'h00, c[7:0]});
    ent.push_back({4'h0, bad, 3'h4, c[15:8]});
  endtask

  // watcher: read data, service requests, transmit bytes and the run limit
  always @(posedge clk) begin
    cyc++;
    if (rd_pend) check(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
    if (channel_service_request === 1'b1 && service_is_rx === 1'b1) rxreq++;
    if (channel_service_request === 1'b1 && service_is_rx === 1'b0) txreq++;
    if (tx_cnt != seen_tx) begin
      check({8'h00, tx_byte}, {8'h00, exp_tx.pop_front()});
      seen_tx++;
    end
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge clk);
    check({13'h0000, tx_line_data, dce_connect, channel_service_request}, 16'h0004);
    resetn <= 1'b1;
    rd(IDX_CTL, 16'h0000);
    rd(IDX_STAT, 16'h0002);
    wr(3'h3, 16'hFFFF);
    rd(3'h3, 16'h0000);
    wr(IDX_CTL, 16'h0001);
    rd(IDX_CTL, 16'h0001);
    repeat (2) @(posedge clk);
    check({15'h0000, dce_connect}, 16'h0001);
    note("registers");
    lwait(2);
    d[0] = rnd();
    d[1] = 8'h7E;
    d[2] = rnd();
    rx_frame(3, 1'b0);
    d[0] = rnd();
    rx_frame(1, 1'b1);
    lwait(12);
    check(16'(rxreq), 16'h0001);
    rd(IDX_STAT, 16'h0003);
    drain();
    rd(IDX_DATA, 16'h0000);
    note("receive");
    d[0] = rnd();
    i_dce.put(FLAG, 1'b1);
    i_dce.put(d[0], 1'b0);
    i_dce.put(8'h01, 1'b0);
    i_dce.put(8'hFF, 1'b1);
    ent.push_back({8'h00, d[0]});
    ent.push_back(16'h0601);
    lwait(6);
    drain();
    rd(IDX_STAT, 16'h0002);
    note("abort");
    for (int i = 0; i < 10; i++) d[i] = rnd();
    rx_frame(10, 1'b0);
    ent.delete();
    for (int i = 0; i < 8; i++) ent.push_back({7'h00, i == 7, d[i]});
    lwait(14);
    drain();
    d[0] = rnd();
    rx_frame(1, 1'b0);
    lwait(5);
    drain();
    note("overrun");
    for (int i = 0; i < 5; i++) i_dce.put(8'hFF, 1'b1);
    ent.push_back(16'h1000);
    lwait(8);
    drain();
    rd(IDX_STAT, 16'h0002);
    note("idle");
    check(16'(txreq), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d[i] = rnd();
      exp_tx.push_back(d[i]);
      wr(IDX_DATA, {6'h00, i == 7, i == 0, d[i]});
    end
    wr(IDX_DATA, 16'h0155);
    rd(IDX_STAT, 16'h0008);
    c = fcs(8);
    exp_tx.push_back(c[7:0]);
    exp_tx.push_back(c[15:8]);
    wr(IDX_CTL, 16'h0007);
    lwait(14);
    check(16'(txreq != 0), 16'h0001);
    rd(IDX_STAT, 16'h0002);
    note("transmit");
    a0 = abort_cnt;
    d[0] = rnd();
    exp_tx.push_back(d[0]);
    wr(IDX_DATA, {8'h01, d[0]});
    lwait(4);
    rd(IDX_STAT, 16'h0006);
    check(16'(abort_cnt - a0), 16'h0001);
    d[0] = rnd();
    d[1] = rnd();
    c = fcs(2);
    exp_tx.push_back(d[0]);
    exp_tx.push_back(d[1]);
    exp_tx.push_back(c[7:0]);
    exp_tx.push_back(c[15:8]);
    wr(IDX_DATA, {8'h01, d[0]});
    wr(IDX_DATA, {8'h02, d[1]});
    lwait(6);
    rd(IDX_STAT, 16'h0002);
    note("underrun");
    wr(IDX_CTL, 16'h0003);
    d[0] = rnd();
    exp_tx.push_back(d[0]);
    wr(IDX_DATA, {8'h03, d[0]});
    lwait(3);
    note("no check sequence");
    wr(IDX_CTL, 16'h0001);
    lwait(2);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(IDX_CTL, 16'h0000);
    check({14'h0000, tx_line_data, dce_connect}, 16'h0002);
    note("master clear");
    repeat (4) @(posedge clk);
    check(16'(exp_q.size() + exp_tx.size()), 16'h0000);
    final_report();
  end
endmodule : hfc_channel_bench
